/* File: hw/flash_poll_cfg.svh */
// offsets, field positions, reset values and timing counts
// assumes a 250 MHz i_clk and the slowest flash speed grade
`ifndef FLASH_POLL_CFG_SVH
`define FLASH_POLL_CFG_SVH

`define CLK_NS       4
`define CYC_UP(ns)   (((ns) + `CLK_NS - 1) / `CLK_NS)
// pin timings in ns, slowest grade so every grade is served
`define T_WP_NS      55
`define T_WPH_NS     20
`define T_ACC_NS     150
`define T_DF_NS      35
`define T_RP_NS      500
`define T_READY_NS   20000
`define WP_CYC       `CYC_UP(`T_WP_NS)
`define WPH_CYC      `CYC_UP(`T_WPH_NS)
`define ACC_CYC      `CYC_UP(`T_ACC_NS)
`define DF_CYC       `CYC_UP(`T_DF_NS)
`define RP_CYC       `CYC_UP(`T_RP_NS)
`define READY_CYC    `CYC_UP(`T_READY_NS)
`define SYNC_CYC     2

// register offsets
`define REG_CTRL     8'h00
`define REG_ADDR     8'h04
`define REG_WDATA    8'h08
`define REG_STATUS   8'h0c
`define REG_RDATA    8'h10
`define REG_CFG      8'h14

// status word bits
`define ST_BUSY      0
`define ST_DONE      1
`define ST_FAIL      2
`define ST_NACC      3
`define ST_READY     4
`define ST_WINPRE    5

// data bus flag positions
`define DQ_POLL      7
`define DQ_TOG       6
`define DQ_FAIL      5
`define DQ_WIN       3

`define CFG_RST      1'b0
`define AXI_OKAY     2'b00
`define AXI_SLVERR   2'b10

`endif

/* File: hw/flash_poll_pkg.sv */
// types shared by the status-polling host and its cycle engine
// assumes nothing beyond a SystemVerilog tool
package flash_poll_pkg;
  typedef enum logic [2:0] {
    OP_WRITE  = 3'b000,
    OP_READ   = 3'b001,
    OP_CPOLL  = 3'b010,
    OP_TPOLL  = 3'b011,
    OP_WINDOW = 3'b100,
    OP_RESET  = 3'b101
  } op_t;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ISSUE   = 3'b001,
    S_WAIT    = 3'b010,
    S_RST     = 3'b011,
    S_RECOVER = 3'b100
  } host_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_RD   = 2'b01,
    E_WR   = 2'b10,
    E_REC  = 2'b11
  } eng_state_t;
endpackage

/* File: hw/cyc_if.sv */
// one flash bus cycle request and its answer
// assumes requester and engine share i_clk
interface cyc_if #(
  parameter int AW = 18,
  parameter int DW = 16
);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          done;
  logic [DW-1:0] rdata;

  modport host   (output req, wr, addr, wdata, input done, rdata);
  modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface

/* File: hw/flash_cycle.sv */
// engine that runs one read or write cycle on the flash pins
// assumes one request at a time, sent only while it is idle
`include "flash_poll_cfg.svh"
module flash_cycle #(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input  logic          i_clk,   // system clock
  input  logic          i_srst,  // sync reset, active high
  cyc_if.engine         cyc,     // request from sequencer
  output logic          o_ce_n,  // chip select, active low
  output logic          o_oe_n,  // output enable, active low
  output logic          o_we_n,  // write strobe, active low
  output logic [AW-1:0] o_addr,  // flash address
  output logic [DW-1:0] o_dq,    // data driven to flash
  output logic          o_dq_oe, // high while host drives data
  input  logic [DW-1:0] i_dq     // data pins as seen
);
  localparam logic [7:0] WP_LEN  = 8'(`WP_CYC - 1);
  localparam logic [7:0] WPH_LEN = 8'(`WPH_CYC - 1);
  localparam logic [7:0] ACC_LEN = 8'(`ACC_CYC + `SYNC_CYC - 1);
  localparam logic [7:0] DF_LEN  = 8'(`DF_CYC - 1);
  localparam int         WP_I    = `WP_CYC;

  flash_poll_pkg::eng_state_t st;
  logic [7:0]    cnt;
  logic [DW-1:0] dq_s1;
  logic [DW-1:0] dq_s2;
  logic [7:0]    we_low;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st        <= flash_poll_pkg::E_IDLE;
      cnt       <= 8'h00;
      o_ce_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_dq_oe   <= 1'b0;
      o_dq      <= '0;
      o_addr    <= '0;
      cyc.done  <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      unique case (st)
        flash_poll_pkg::E_IDLE: if (cyc.req) begin
          o_addr <= cyc.addr;
          o_ce_n <= 1'b0;
          if (cyc.wr) begin
            o_we_n  <= 1'b0;
            o_dq_oe <= 1'b1;
            o_dq    <= cyc.wdata;
            cnt     <= WP_LEN;
            st      <= flash_poll_pkg::E_WR;
          end else begin
            o_oe_n <= 1'b0;
            cnt    <= ACC_LEN;
            st     <= flash_poll_pkg::E_RD;
          end
        end
        flash_poll_pkg::E_WR: if (cnt == 8'h00) begin
          o_we_n  <= 1'b1;
          o_ce_n  <= 1'b1;
          o_dq_oe <= 1'b0;
          cnt     <= WPH_LEN;
          st      <= flash_poll_pkg::E_REC;
        end else begin
          cnt <= cnt - 8'h01;
        end
        flash_poll_pkg::E_RD: if (cnt == 8'h00) begin
          cyc.rdata <= dq_s2;
          o_oe_n    <= 1'b1;
          o_ce_n    <= 1'b1;
          cnt       <= DF_LEN;
          st        <= flash_poll_pkg::E_REC;
        end else begin
          cnt <= cnt - 8'h01;
        end
        flash_poll_pkg::E_REC: if (cnt == 8'h00) begin
          cyc.done <= 1'b1;
          st       <= flash_poll_pkg::E_IDLE;
        end else begin
          cnt <= cnt - 8'h01;
        end
      endcase
    end
  end

  // counts write-strobe low time for the width check
  always_ff @(posedge i_clk) begin
    if (i_srst || o_we_n) we_low <= 8'h00;
    else we_low <= we_low + 8'h01;
  end

  no_contention_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_oe_n |-> !o_dq_oe) else $error("host drives data while oe low");

  we_width_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_we_n) |-> we_low == 8'(WP_I)) else $error("write pulse width");

  oe_release_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_oe_n) |-> ##[40:41] $rose(o_oe_n) && $rose(o_ce_n))
    else $error("read cycle did not release select");
endmodule

/* File: hw/flash_status_host.sv */
// host controller that runs cycles on a parallel flash and polls
// its write status; software drives it over axi4-lite
// assumes the flash pins are wired direct, dq resolved on the board
`include "flash_poll_cfg.svh"
module flash_status_host #(
  parameter int AW        = 18,
  parameter int DW        = 16,
  parameter int READY_CYC = `READY_CYC
) (
  input  logic          i_clk,     // system clock, 250 MHz
  input  logic          i_srst,    // sync reset, active high
  input  logic [7:0]    i_awaddr,  // axi write address
  input  logic          i_awvalid, // axi write address valid
  output logic          o_awready, // axi write address ready
  input  logic [31:0]   i_wdata,   // axi write data
  input  logic [3:0]    i_wstrb,   // axi byte strobes
  input  logic          i_wvalid,  // axi write data valid
  output logic          o_wready,  // axi write data ready
  output logic [1:0]    o_bresp,   // axi write response
  output logic          o_bvalid,  // axi write response valid
  input  logic          i_bready,  // axi write response ready
  input  logic [7:0]    i_araddr,  // axi read address
  input  logic          i_arvalid, // axi read address valid
  output logic          o_arready, // axi read address ready
  output logic [31:0]   o_rdata,   // axi read data
  output logic [1:0]    o_rresp,   // axi read response
  output logic          o_rvalid,  // axi read data valid
  input  logic          i_rready,  // axi read data ready
  output logic          o_ce_n,    // flash chip select, low
  output logic          o_oe_n,    // flash output enable, low
  output logic          o_we_n,    // flash write strobe, low
  output logic          o_rst_n,   // flash reset pin, low
  output logic [AW-1:0] o_addr,    // flash address
  output logic [DW-1:0] o_dq,      // data toward flash
  output logic          o_dq_oe,   // high while host drives dq
  input  logic [DW-1:0] i_dq,      // flash data pins
  input  logic          i_ready_busy // ready_busy_output pin
);
  localparam logic [15:0] RP_LEN    = 16'(`RP_CYC - 1);
  localparam logic [15:0] READY_LEN = 16'(READY_CYC - 1);

  cyc_if #(.AW(AW), .DW(DW)) cyc ();

  flash_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .cyc     (cyc),
    .o_ce_n  (o_ce_n),
    .o_oe_n  (o_oe_n),
    .o_we_n  (o_we_n),
    .o_addr  (o_addr),
    .o_dq    (o_dq),
    .o_dq_oe (o_dq_oe),
    .i_dq    (i_dq)
  );

  flash_poll_pkg::host_state_t state;
  flash_poll_pkg::op_t         op;
  logic [1:0]    ready_sync;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic          cfg_auto_rst;
  logic [1:0]    step;
  logic          seen_fail;
  logic [DW-1:0] prev;
  logic [DW-1:0] rd_last;
  logic          fail;
  logic          not_acc;
  logic          win_pre;
  logic          done;
  logic [15:0]   cnt;
  logic          aw_hold;
  logic          w_hold;
  logic [7:0]    aw_off;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          wr_fire;
  logic          start_req;
  logic          wr_ok;
  logic [31:0]   status_w;
  logic [31:0]   next_rdata;
  logic [1:0]    next_rresp;
  logic          fail_path;
  logic          busy;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_srst) ready_sync <= 2'b00;
    else ready_sync <= {ready_sync[0], i_ready_busy};
  end

  assign busy      = (state != flash_poll_pkg::S_IDLE);
  assign wr_fire   = aw_hold && w_hold && !o_bvalid;
  // codes above reset are illegal and refused
  assign start_req = wr_fire && aw_off == `REG_CTRL && w_strb_q[0] &&
                     !busy && w_data_q[2:0] <= 3'b101;
  assign wr_ok     = start_req || aw_off == `REG_ADDR ||
                     aw_off == `REG_WDATA || aw_off == `REG_CFG;
  assign cyc.addr  = addr_r;
  assign cyc.wdata = wdata_r;
  assign fail_path = cfg_auto_rst;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_awready <= 1'b0;
      aw_hold   <= 1'b0;
      aw_off    <= 8'h00;
    end else if (o_awready && i_awvalid) begin
      o_awready <= 1'b0;
      aw_hold   <= 1'b1;
      aw_off    <= i_awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end else if (!aw_hold && !o_bvalid) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wready <= 1'b0;
      w_hold   <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (o_wready && i_wvalid) begin
      o_wready <= 1'b0;
      w_hold   <= 1'b1;
      w_data_q <= i_wdata;
      w_strb_q <= i_wstrb;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end else if (!w_hold && !o_bvalid) begin
      o_wready <= 1'b1;
    end
  end

  // a busy controller refuses a new start with slverr
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `AXI_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr_r       <= '0;
      wdata_r      <= '0;
      cfg_auto_rst <= `CFG_RST;
    end else if (wr_fire) begin
      if (aw_off == `REG_ADDR)
        addr_r <= AW'(merge(32'(addr_r), w_data_q, w_strb_q));
      if (aw_off == `REG_WDATA)
        wdata_r <= DW'(merge(32'(wdata_r), w_data_q, w_strb_q));
      if (aw_off == `REG_CFG && w_strb_q[0])
        cfg_auto_rst <= w_data_q[0];
    end
  end

  always_comb begin
    status_w               = 32'h0000_0000;
    status_w[`ST_BUSY]     = busy;
    status_w[`ST_DONE]     = done;
    status_w[`ST_FAIL]     = fail;
    status_w[`ST_NACC]     = not_acc;
    status_w[`ST_READY]    = ready_sync[1];
    status_w[`ST_WINPRE]   = win_pre;
    next_rresp             = `AXI_OKAY;
    case (i_araddr)
      `REG_CTRL:   next_rdata = {29'h0, op};
      `REG_ADDR:   next_rdata = 32'(addr_r);
      `REG_WDATA:  next_rdata = 32'(wdata_r);
      `REG_STATUS: next_rdata = status_w;
      `REG_RDATA:  next_rdata = 32'(rd_last);
      `REG_CFG:    next_rdata = {31'h0, cfg_auto_rst};
      default: begin
        next_rdata = 32'h0000_0000;
        next_rresp = `AXI_SLVERR;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `AXI_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= next_rdata;
      o_rresp   <= next_rresp;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  // sequencer: one op runs its reads and writes to completion
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state     <= flash_poll_pkg::S_IDLE;
      op        <= flash_poll_pkg::OP_WRITE;
      step      <= 2'b00;
      seen_fail <= 1'b0;
      prev      <= '0;
      rd_last   <= '0;
      fail      <= 1'b0;
      not_acc   <= 1'b0;
      win_pre   <= 1'b0;
      done      <= 1'b0;
      cnt       <= 16'h0000;
      o_rst_n   <= 1'b1;
      cyc.req   <= 1'b0;
      cyc.wr    <= 1'b0;
    end else begin
      cyc.req <= 1'b0;
      unique case (state)
        flash_poll_pkg::S_IDLE: if (start_req) begin
          op        <= flash_poll_pkg::op_t'(w_data_q[2:0]);
          step      <= 2'b00;
          seen_fail <= 1'b0;
          fail      <= 1'b0;
          not_acc   <= 1'b0;
          win_pre   <= 1'b0;
          done      <= 1'b0;
          cnt       <= RP_LEN;
          state     <= (w_data_q[2:0] == 3'b101) ?
                       flash_poll_pkg::S_RST : flash_poll_pkg::S_ISSUE;
        end
        flash_poll_pkg::S_ISSUE: begin
          cyc.req <= 1'b1;
          cyc.wr  <= op == flash_poll_pkg::OP_WRITE ||
                     (op == flash_poll_pkg::OP_WINDOW && step == 2'b01);
          state   <= flash_poll_pkg::S_WAIT;
        end
        flash_poll_pkg::S_WAIT: if (cyc.done) begin
          rd_last <= cyc.wr ? rd_last : cyc.rdata;
          state   <= flash_poll_pkg::S_ISSUE;
          case (op)
            flash_poll_pkg::OP_CPOLL: begin
              if (cyc.rdata[`DQ_POLL] == wdata_r[`DQ_POLL]) begin
                state <= flash_poll_pkg::S_IDLE;
                done  <= 1'b1;
              end else if (step == 2'b01) begin
                fail  <= 1'b1;
                cnt   <= RP_LEN;
                done  <= !fail_path;
                state <= fail_path ? flash_poll_pkg::S_RST :
                                     flash_poll_pkg::S_IDLE;
              end else if (cyc.rdata[`DQ_FAIL]) begin
                step <= 2'b01;
              end
            end
            flash_poll_pkg::OP_TPOLL: begin
              prev <= cyc.rdata;
              if (step == 2'b00) begin
                step <= 2'b01;
              end else if (cyc.rdata[`DQ_TOG] == prev[`DQ_TOG]) begin
                state <= flash_poll_pkg::S_IDLE;
                done  <= 1'b1;
              end else if (seen_fail) begin
                fail  <= 1'b1;
                cnt   <= RP_LEN;
                done  <= !fail_path;
                state <= fail_path ? flash_poll_pkg::S_RST :
                                     flash_poll_pkg::S_IDLE;
              end else if (cyc.rdata[`DQ_FAIL]) begin
                seen_fail <= 1'b1;
                step      <= 2'b00;
              end
            end
            flash_poll_pkg::OP_WINDOW: begin
              step <= step + 2'b01;
              if (step == 2'b00) win_pre <= cyc.rdata[`DQ_WIN];
              if (step == 2'b10) begin
                not_acc <= cyc.rdata[`DQ_WIN];
                done    <= 1'b1;
                state   <= flash_poll_pkg::S_IDLE;
              end
            end
            default: begin
              done  <= 1'b1;
              state <= flash_poll_pkg::S_IDLE;
            end
          endcase
        end
        flash_poll_pkg::S_RST: begin
          o_rst_n <= 1'b0;
          if (cnt == 16'h0000) begin
            cnt   <= READY_LEN;
            state <= flash_poll_pkg::S_RECOVER;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        flash_poll_pkg::S_RECOVER: begin
          o_rst_n <= 1'b1;
          if (cnt == 16'h0000) begin
            done  <= 1'b1;
            state <= flash_poll_pkg::S_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: state <= flash_poll_pkg::S_IDLE;
      endcase
    end
  end

  sequence win_write_done;
    state == flash_poll_pkg::S_WAIT && cyc.done &&
    op == flash_poll_pkg::OP_WINDOW && step == 2'b01;
  endsequence

  cpoll_recheck_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == flash_poll_pkg::S_WAIT && cyc.done && step == 2'b00 &&
     op == flash_poll_pkg::OP_CPOLL && cyc.rdata[`DQ_FAIL] &&
     cyc.rdata[`DQ_POLL] != wdata_r[`DQ_POLL])
    |=> state == flash_poll_pkg::S_ISSUE && step == 2'b01 && !fail)
    else $error("polling bit not rechecked");
  tpoll_recheck_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(fail) && op == flash_poll_pkg::OP_TPOLL |-> $past(seen_fail))
    else $error("toggle failure without recheck");
  auto_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(fail) && cfg_auto_rst |=> !o_rst_n)
    else $error("no reset after failure");
  rst_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_rst_n) |-> !o_rst_n [*8]) else $error("reset pulse short");
  win_recheck_a: assert property (@(posedge i_clk) disable iff (i_srst)
    win_write_done |=> state == flash_poll_pkg::S_ISSUE && step == 2'b10)
    else $error("window bit not read after write");
  bresp_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
endmodule

/* File: testbench/flash_dev_model.sv */
// behavioural flash that answers status reads on its pins
// assumes host pins wired direct, dq resolved by the bench
module flash_dev_model (
  input  wire logic        i_ce_n,       // chip select, low
  input  wire logic        i_oe_n,       // output enable, low
  input  wire logic        i_we_n,       // write strobe, low
  input  wire logic        i_rst_n,      // reset pin, low
  input  wire logic [15:0] i_dq,         // data from host
  input  wire logic [7:0]  i_busy,       // reads until done
  input  wire logic        i_fail,       // algorithm times out
  input  wire logic        i_erase,      // next write is an erase
  output logic      [15:0] o_dq,         // data toward host
  output logic             o_ready_busy  // ready_busy_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem = 16'h0000;
  logic [15:0] held = 16'h0000;
  logic [15:0] rd;
  logic        tog = 1'b0;
  logic        ers = 1'b0;
  int          left = 0;
  wire         drv = !i_ce_n && !i_oe_n;
  wire  [15:0] dq_d;
  wire         ce_d;
  // host lifts strobe, select and data in one step: look 1 ns back
  assign #1 dq_d = i_dq;
  assign #1 ce_d = i_ce_n;
  // status from the last strobe, refused while busy
  always @(posedge i_we_n) if (!ce_d && left == 0) begin
    ers = i_erase;
    mem = i_erase ? 16'hffff : dq_d;
    left = i_busy;
  end
  // toggle bit flips on each enabled read while busy; the secondary one shows it only during an erase
  always @(posedge drv) if (left > 0) begin
    tog = ~tog;
    if (!i_fail) left = left - 1;
  end
  always @(negedge i_rst_n) left = 0;
  // window bit shows the erase flag while busy, stored data bit 3 when idle
  always @* rd = (left > 0) ? {mem[15:8], ~mem[7], tog, i_fail, mem[4],
                               ers, ers & tog, mem[1:0]} : mem;
  // released bus never shows the old value
  always @(negedge drv) held = rd;
  assign o_dq = drv ? rd : ~held;
  assign o_ready_busy = (left == 0);
endmodule

/* File: testbench/flash_status_host_tb_top.sv */
// self-checking bench for the status-polling flash host
// assumes the device model answers on the flash pins
`include "flash_poll_cfg.svh"
module flash_status_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_srst = 1;
  logic [7:0]  awaddr = 0, araddr = 0, busy = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, fail_in = 0, erase_in = 0;
  logic [31:0] wdata = 0, rdata, rd, p;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ce_n, oe_n, we_n, rst_n, dq_oe, ready_busy;
  logic [17:0] addr;
  logic [15:0] hdq, mdq, d;
  wire  [15:0] dq = dq_oe ? hdq : mdq;
  int          fails = 0, checks = 0;
  flash_status_host #(.READY_CYC(20)) dut_u (
    .i_clk(i_clk), .i_srst(i_srst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_rst_n(rst_n), .o_addr(addr), .o_dq(hdq), .o_dq_oe(dq_oe),
    .i_dq(dq), .i_ready_busy(ready_busy));
  flash_dev_model dev_u (
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(rst_n),
    .i_dq(dq), .i_busy(busy), .i_fail(fail_in), .i_erase(erase_in),
    .o_dq(mdq), .o_ready_busy(ready_busy));
  initial forever #2 i_clk = ~i_clk;
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_clk);
      ad = ad || awready;
      wd = wd || wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (rvalid !== 1'b1);
    rd = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // start an op, then read status until it reports done
  task automatic op(input flash_poll_pkg::op_t c);
    int n;
    axw(`REG_CTRL, {29'h0, c});
    n = 0;
    do begin
      axr(`REG_STATUS);
      n++;
    end while (rd[`ST_DONE] !== 1'b1 && n < 500);
    chk("op done", 1'b1, rd[`ST_DONE]);
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    fails++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hc8cc61ab));
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    axr(8'h40);
    chk("unmapped rresp", `AXI_SLVERR, r);
    axw(`REG_CTRL, 32'h6);
    chk("ctrl code 6 bresp", `AXI_SLVERR, r);
    $display("refusal test done");
    // pass 2 erases; last two time out, the last resets by itself
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom);
      if (i == 2) d[7] = 1'b1;
      fail_in <= (i >= 4);
      erase_in <= (i == 2);
      busy <= 8'(3 + $urandom_range(3));
      axw(`REG_CFG, i == 5);
      axw(`REG_ADDR, $urandom_range(18'h3ffff));
      axw(`REG_WDATA, {16'h0, d});
      op(flash_poll_pkg::OP_WRITE);
      op(flash_poll_pkg::OP_READ);
      axr(`REG_RDATA);
      p = rd;
      chk("busy poll bit", erase_in ? 1'b0 : !d[7], rd[7]);
      chk("busy fail bit", fail_in, rd[5]);
      chk("busy window bit", erase_in, rd[3]);
      op(flash_poll_pkg::OP_READ);
      axr(`REG_RDATA);
      chk("primary toggle", !p[6], rd[6]);
      chk("secondary toggle", p[2] ^ erase_in, rd[2]);
      op(i[0] ? flash_poll_pkg::OP_TPOLL : flash_poll_pkg::OP_CPOLL);
      chk("poll failed", fail_in, rd[`ST_FAIL]);
      chk("ready pin", !fail_in || i == 5, rd[`ST_READY]);
      if (!fail_in) begin
        axr(`REG_RDATA);
        chk("final data", erase_in ? 16'hffff : d, rd[15:0]);
        op(flash_poll_pkg::OP_WINDOW);
        chk("window before", erase_in | d[3], rd[`ST_WINPRE]);
        chk("window after", erase_in, rd[`ST_NACC]);
        op(flash_poll_pkg::OP_CPOLL);
        chk("window poll", 1'b0, rd[`ST_FAIL]);
      end else begin
        op(flash_poll_pkg::OP_RESET);
        chk("ready after reset", 1'b1, rd[`ST_READY]);
      end
      $display("poll test %0d done", i);
    end
    finish_test();
  end
endmodule
